// ### rtl/mcd_regs.svh
// register offsets, field positions, reset values and masks of the mac control datapath
`ifndef MCD_REGS_SVH
`define MCD_REGS_SVH

// =====================================================================
// register byte addresses (index times four)
`define MCD_ADDR_W 8
`define MCD_CTRL_ONE_ADDR 8'h44
`define MCD_RAM_PTRS_ADDR 8'h4C
`define MCD_PIPE_OUT_ADDR 8'h54
`define MCD_ACC_LO_ADDR 8'h70
`define MCD_ACC_HI_ADDR 8'h74
`define MCD_WORD_OUT_ADDR 8'h78

// =====================================================================
// control register one: reset value and writable bits
`define MCD_CTRL_ONE_RESET 32'h0000_0000
`define MCD_CTRL_ONE_WMASK 32'h6C3F_7F9F

// =====================================================================
// pointer register field positions
`define MCD_PTR_W 7
`define MCD_RD_PTR_LSB 0
`define MCD_WR_PTR_LSB 8
`define MCD_PTR_RESET 7'h00

// =====================================================================
// datapath widths
`define MCD_ACC_W 64
`define MCD_WORD_W 32
`define MCD_LANES 4

`endif

// ### rtl/mcd_pkg.sv
// types shared by the mac control datapath
package mcd_pkg;

  typedef enum logic [1:0] {
    MCD_QUAD_BYTE,
    MCD_DOUBLE_SHORT,
    MCD_SINGLE_WORD,
    MCD_SIZE_SPARE
  } mcd_size_t;

  typedef enum logic [1:0] {
    MCD_INTEGER,
    MCD_NORMALISED,
    MCD_FIXED_POINT,
    MCD_GRAPHICS
  } mcd_type_t;

  // full layout of control register one, bit 31 first
  typedef struct packed {
    logic z31;
    logic [1:0] vram_write_ctrl;
    logic z28;
    logic [1:0] vram_read_ctrl;
    logic [3:0] z25_22;
    mcd_size_t operand_size;
    mcd_type_t operand_type;
    logic first_operand_signed;
    logic second_operand_signed;
    logic z15;
    logic [2:0] adder_input_select;
    logic round_product;
    logic [2:0] out_shift;
    logic clip_unit_enable;
    logic [1:0] z6_5;
    logic coef_shift_enable;
    logic pipe_shift_enable;
    logic [2:0] transpose_ctrl;
  } mcd_ctrl_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mcd_bus_req_t;

  // basic multiply event from the execution unit
  typedef struct packed {
    logic valid;
    mcd_size_t mb_size;
    logic [3:0] func;
  } mcd_basic_op_t;

endpackage

// ### rtl/mcd_mac_control.sv
// control register one and the datapath it steers: vector ram, accumulator, output, pipeline, transposer
//
// Overview of operation
// RULE_01: write field: 00 none, 10 write, 11 write+increment
// RULE_02: read field: 00 none, 10 read, 11 read+increment
// RULE_03: separate seven-bit read and write pointers
// RULE_04: basic op loads size from operand input
// RULE_05: size: four bytes, two shorts, one word
// RULE_06: basic op loads type and sign bits
// RULE_07: type: integer, normalised, fixed point, graphics
// RULE_08: sign bit: 0 unsigned, 1 two's complement
// RULE_09: adder sums two of accumulator, ram, product
// RULE_10: sum stored in accumulator, then written to ram
// RULE_11: round adds half output lsb to product
// RULE_12: output word: low, middle or high part
// RULE_13: shift codes 100-111 select 0-3 lower
// RULE_14: one bit enables or bypasses range clip
// RULE_15: pipe-load shifts data pipeline right to left
// RULE_16: coefficient rows shift bottom to top or hold
// RULE_17: inner product shifts pipeline; last stage readable
// RULE_18: transpose copies coefficients when counter is zero
// RULE_19: transpose counter post-increments modulo four
// RULE_20: write 000 clears, 1xx sets with preset
// RULE_21: fixed-zero bits read zero, ignore writes
`timescale 1ns/10ps
`include "mcd_regs.svh"

module mcd_mac_control
  import mcd_pkg::*;
#(
  parameter int RAM_DEPTH = 128,
  parameter int PTR_W = `MCD_PTR_W
) (
  input wire logic i_clock,                     // 125 MHz system clock
  input wire logic i_arst_n,                    // asynchronous reset, active low
  input wire mcd_bus_req_t i_bus,               // register bus request
  output logic [31:0] o_rdata,                  // read data, cycle after read strobe
  input wire mcd_basic_op_t i_basic_op,         // basic multiply executes
  input wire logic i_mac_step,                  // extended accumulate step
  input wire logic [`MCD_ACC_W-1:0] i_product,  // multiplier result
  input wire logic i_loadpipe,                  // pipe-load operation
  input wire logic i_inproduct,                 // inner-product operation
  input wire logic [31:0] i_pipe_data,          // 4x8 data into right of pipeline
  input wire logic [31:0] i_coef_row,           // 4x8 row into bottom of coefficients
  output mcd_ctrl_t o_ctrl,                     // control register one contents
  output logic [`MCD_ACC_W-1:0] o_acc,          // accumulator register
  output logic [`MCD_WORD_W-1:0] o_word,        // selected output word
  output logic o_clip_enable,                   // range clip stage active
  output logic [31:0] o_pipe_last,              // last data pipeline stage
  output logic [127:0] o_pipe_all               // all pipeline stages, last on top
);

  // =====================================================================
  // storage
  mcd_ctrl_t ctrl_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W-1:0] wr_ptr_q;
  logic [`MCD_ACC_W-1:0] acc_q;
  logic [`MCD_ACC_W-1:0] acc_d;
  logic [`MCD_ACC_W-1:0] vram_q [RAM_DEPTH];
  logic [`MCD_WORD_W-1:0] word_q;
  logic [31:0] pipe_q [`MCD_LANES];
  logic [31:0] coef_q [`MCD_LANES];
  logic [31:0] rdata_q;

  // =====================================================================
  // decode
  logic wr_ctrl;
  logic wr_ptrs;
  logic [31:0] wdata_ctrl;
  logic ram_read_en;
  logic ram_read_inc;
  logic ram_write_en;
  logic ram_write_inc;
  logic transpose_mode;
  logic transpose_copy;
  logic pipe_shift;
  logic [`MCD_ACC_W-1:0] ram_rdata;
  logic [`MCD_ACC_W-1:0] product_rnd;
  logic [1:0] shift_amt;

  assign wr_ctrl = i_bus.wr && (i_bus.addr == `MCD_CTRL_ONE_ADDR);
  assign wr_ptrs = i_bus.wr && (i_bus.addr == `MCD_RAM_PTRS_ADDR);
  assign wdata_ctrl = i_bus.wdata & `MCD_CTRL_ONE_WMASK; // RULE_21

  assign ram_read_en = ctrl_q.vram_read_ctrl[1];                            // RULE_02
  assign ram_read_inc = ctrl_q.vram_read_ctrl == 2'b11;                     // RULE_02
  assign ram_write_en = ctrl_q.vram_write_ctrl[1];                          // RULE_01
  assign ram_write_inc = ctrl_q.vram_write_ctrl == 2'b11;                   // RULE_01

  // codes 0xx of the shift field act as plain x1
  assign shift_amt = ctrl_q.out_shift[2] ? ctrl_q.out_shift[1:0] : 2'b00; // RULE_13

  assign transpose_mode = ctrl_q.transpose_ctrl[2];
  assign transpose_copy = i_loadpipe && transpose_mode && (ctrl_q.transpose_ctrl[1:0] == 2'b00); // RULE_18
  assign pipe_shift = (i_loadpipe && ctrl_q.pipe_shift_enable) || i_inproduct; // RULE_15 RULE_17

  // =====================================================================
  // lane helpers
  function automatic int lane_width(input mcd_size_t sz);
    int lw;
    begin
      case (sz)
        MCD_QUAD_BYTE: lw = 8;                                              // RULE_05
        MCD_DOUBLE_SHORT: lw = 16;                                          // RULE_05
        default: lw = 32;                                                   // RULE_05
      endcase
      return lw;
    end
  endfunction

  // lsb position of the output field within one internal lane
  function automatic int lane_offset(input mcd_type_t ty, input int lw);
    int off;
    begin
      case (ty)
        MCD_FIXED_POINT: off = lw / 2;                                      // RULE_12
        MCD_NORMALISED: off = lw;                                           // RULE_12
        default: off = 0;                                                   // RULE_07 RULE_12
      endcase
      return off;
    end
  endfunction

  // per-lane selection of the output word from the double-width result
  function automatic logic [31:0] select_word(input logic [63:0] acc, input mcd_size_t sz,
                                              input mcd_type_t ty, input logic [1:0] sh);
    int lw;
    int off;
    int base;
    int src;
    logic [31:0] r;
    begin
      r = '0;
      lw = lane_width(sz);
      off = lane_offset(ty, lw);
      for (int i = 0; i < 32; i++) begin
        base = (i / lw) * 2 * lw;
        src = base + off + (i % lw) - int'(sh);                              // RULE_13
        // bits shifted in below the lane read as zero
        if (src >= base) begin
          r[i] = acc[src];
        end
      end
      return r;
    end
  endfunction

  // half an output lsb in every lane; carries may ripple between lanes
  function automatic logic [63:0] round_vector(input mcd_size_t sz, input mcd_type_t ty,
                                               input logic [1:0] sh);
    int lw;
    int pos;
    logic [63:0] v;
    begin
      v = '0;
      lw = lane_width(sz);
      pos = lane_offset(ty, lw) - int'(sh);
      // integer output has no fraction below its lsb, so nothing to round
      if (pos > 0) begin
        for (int l = 0; l < 4; l++) begin
          if (l * lw < 32) begin
            v[l * 2 * lw + pos - 1] = 1'b1;                                 // RULE_11
          end
        end
      end
      return v;
    end
  endfunction

  // =====================================================================
  // control register one
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= mcd_ctrl_t'(`MCD_CTRL_ONE_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= mcd_ctrl_t'(wdata_ctrl);                                  // RULE_21
        // codes 001-011 are not defined; treated as clear
        if (!i_bus.wdata[2]) begin
          ctrl_q.transpose_ctrl <= 3'b000;                                  // RULE_20
        end
      end else if (i_loadpipe && transpose_mode) begin
        ctrl_q.transpose_ctrl[1:0] <= ctrl_q.transpose_ctrl[1:0] + 2'b01;   // RULE_19
      end
      // execution overrides software on the fields it owns
      if (i_basic_op.valid) begin
        ctrl_q.operand_size <= i_basic_op.mb_size;                          // RULE_04
        ctrl_q.operand_type <= mcd_type_t'(i_basic_op.func[3:2]);           // RULE_06
        ctrl_q.first_operand_signed <= i_basic_op.func[1];                  // RULE_06 RULE_08
        ctrl_q.second_operand_signed <= i_basic_op.func[0];                 // RULE_06 RULE_08
      end
    end
  end

  // =====================================================================
  // vector ram pointers; a software write wins over a post-increment
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ptr_q <= PTR_W'(`MCD_PTR_RESET);
      wr_ptr_q <= PTR_W'(`MCD_PTR_RESET);
    end else if (wr_ptrs) begin
      rd_ptr_q <= i_bus.wdata[`MCD_RD_PTR_LSB +: PTR_W];                    // RULE_03
      wr_ptr_q <= i_bus.wdata[`MCD_WR_PTR_LSB +: PTR_W];                    // RULE_03
    end else if (i_mac_step) begin
      if (ram_read_inc) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;                                        // RULE_02 RULE_03
      end
      if (ram_write_inc) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;                                        // RULE_01 RULE_03
      end
    end
  end

  // =====================================================================
  // vector ram: read beside the product, write from the accumulator
  assign ram_rdata = ram_read_en ? vram_q[rd_ptr_q] : '0;                   // RULE_02

  always_ff @(posedge i_clock) begin
    if (i_mac_step && ram_write_en) begin
      vram_q[wr_ptr_q] <= acc_q;                                            // RULE_01 RULE_10
    end
  end

  // =====================================================================
  // accumulator adder
  assign product_rnd = ctrl_q.round_product ?
                       i_product + round_vector(ctrl_q.operand_size, ctrl_q.operand_type, shift_amt) :
                       i_product;                                           // RULE_11

  always_comb begin
    case (ctrl_q.adder_input_select)
      3'b000: acc_d = '0;                                                   // RULE_09
      3'b001: acc_d = product_rnd;                                          // RULE_09
      3'b010: acc_d = ram_rdata;                                            // RULE_09
      3'b011: acc_d = ram_rdata + product_rnd;                              // RULE_09
      3'b100: acc_d = acc_q;                                                // RULE_09
      3'b101: acc_d = acc_q + product_rnd;                                  // RULE_09
      3'b110: acc_d = acc_q + ram_rdata;                                    // RULE_09
      default: acc_d = acc_q;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_q <= '0;
    end else if (i_mac_step) begin
      acc_q <= acc_d;                                                       // RULE_10
    end
  end

  // =====================================================================
  // output word, one cycle behind the accumulator
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_q <= '0;
    end else begin
      word_q <= select_word(acc_q, ctrl_q.operand_size, ctrl_q.operand_type, shift_amt); // RULE_12 RULE_13
    end
  end

  // =====================================================================
  // data pipeline: index 0 is the right end, index 3 the last stage
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < `MCD_LANES; k++) begin
        pipe_q[k] <= '0;
      end
    end else if (transpose_copy) begin
      // column k of the pipeline takes row k of the coefficients
      for (int k = 0; k < `MCD_LANES; k++) begin
        pipe_q[k] <= coef_q[k];                                             // RULE_18
      end
    end else if (pipe_shift) begin
      pipe_q[0] <= i_pipe_data;                                             // RULE_15
      for (int k = 1; k < `MCD_LANES; k++) begin
        pipe_q[k] <= pipe_q[k-1];                                           // RULE_15 RULE_17
      end
    end
  end

  // =====================================================================
  // coefficient rows: index 3 is the bottom, index 0 the top
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < `MCD_LANES; k++) begin
        coef_q[k] <= '0;
      end
    end else if (i_loadpipe && ctrl_q.coef_shift_enable) begin
      coef_q[`MCD_LANES-1] <= i_coef_row;                                   // RULE_16
      for (int k = 0; k < `MCD_LANES - 1; k++) begin
        coef_q[k] <= coef_q[k+1];                                           // RULE_16
      end
    end
  end

  // =====================================================================
  // register read port
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        `MCD_CTRL_ONE_ADDR: rdata_q <= 32'(ctrl_q) & `MCD_CTRL_ONE_WMASK;   // RULE_21
        `MCD_RAM_PTRS_ADDR: begin
          rdata_q <= '0;
          rdata_q[`MCD_RD_PTR_LSB +: PTR_W] <= rd_ptr_q;                    // RULE_03
          rdata_q[`MCD_WR_PTR_LSB +: PTR_W] <= wr_ptr_q;                    // RULE_03
        end
        `MCD_PIPE_OUT_ADDR: rdata_q <= pipe_q[`MCD_LANES-1];               // RULE_17
        `MCD_ACC_LO_ADDR: rdata_q <= acc_q[31:0];
        `MCD_ACC_HI_ADDR: rdata_q <= acc_q[63:32];
        `MCD_WORD_OUT_ADDR: rdata_q <= word_q;
        default: rdata_q <= '0;
      endcase
    end else begin
      // read data stand only in the cycle after the strobe
      rdata_q <= '0;
    end
  end

  // =====================================================================
  // outputs
  assign o_rdata = rdata_q;
  assign o_ctrl = ctrl_q;
  assign o_acc = acc_q;
  assign o_word = word_q;
  assign o_clip_enable = ctrl_q.clip_unit_enable;                           // RULE_14
  assign o_pipe_last = pipe_q[`MCD_LANES-1];
  assign o_pipe_all = {pipe_q[3], pipe_q[2], pipe_q[1], pipe_q[0]};

endmodule

// ### bench/mcd_mac_control_props.sv
// concurrent checks on the mac control datapath ports
`timescale 1ns/10ps
`include "mcd_regs.svh"

module mcd_mac_control_props
  import mcd_pkg::*;
(
  input wire logic i_clock,            // clock
  input wire logic i_arst_n,           // reset, active low
  input wire mcd_bus_req_t i_bus,      // bus request
  input wire logic [31:0] o_rdata,     // read data
  input wire mcd_basic_op_t i_basic_op, // basic op
  input wire logic i_mac_step,         // accumulate step
  input wire logic [63:0] i_product,   // product
  input wire logic i_loadpipe,         // pipe-load
  input wire logic i_inproduct,        // inner product
  input wire logic [31:0] i_pipe_data, // pipeline column
  input wire mcd_ctrl_t o_ctrl,        // control register
  input wire logic [63:0] o_acc,       // accumulator
  input wire logic [31:0] o_word,      // output word
  input wire logic o_clip_enable,      // clip active
  input wire logic [31:0] o_pipe_last, // last stage
  input wire logic [127:0] o_pipe_all  // all stages
);
  // ======================================================================
  // shared clock and reset
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_acc_step;
    i_mac_step && o_ctrl.adder_input_select == 3'b101 && !o_ctrl.round_product;
  endsequence
  // transpose mode excluded: a copy may replace the shift
  sequence s_pipe_move;
    (i_inproduct || (i_loadpipe && o_ctrl.pipe_shift_enable)) && !(i_loadpipe && o_ctrl.transpose_ctrl[2]);
  endsequence

  chk_clip_follows: assert property (i_bus.wr && i_bus.addr == `MCD_CTRL_ONE_ADDR
    |=> o_clip_enable == $past(i_bus.wdata[7]))
    else $error("clip enable differs from written bit");
  chk_ctrl_zero: assert property ((o_ctrl & ~32'h6C3F_7F9F) == 32'h0000_0000)
    else $error("fixed zero control bit set");
  chk_ctrl_readback: assert property (i_bus.rd && i_bus.addr == `MCD_CTRL_ONE_ADDR
    |=> o_rdata == $past(o_ctrl))
    else $error("control read data wrong");
  chk_basic_load: assert property (i_basic_op.valid
    |=> o_ctrl[21:16] == {$past(i_basic_op.mb_size), $past(i_basic_op.func)})
    else $error("basic op did not load size and type");
  chk_acc_step: assert property (s_acc_step |=> o_acc == $past(o_acc) + $past(i_product))
    else $error("accumulate sum wrong");
  chk_acc_clear: assert property (i_mac_step && o_ctrl.adder_input_select == 3'b000 |=> o_acc == 64'h0)
    else $error("accumulator not cleared");
  chk_pipe_hold: assert property (!i_loadpipe && !i_inproduct |=> $stable(o_pipe_all))
    else $error("pipeline moved without an operation");
  chk_pipe_shift: assert property (s_pipe_move
    |=> o_pipe_all == {$past(o_pipe_all[95:0]), $past(i_pipe_data)})
    else $error("pipeline shift wrong");
  chk_last_stage: assert property (i_bus.rd && i_bus.addr == `MCD_PIPE_OUT_ADDR
    |=> o_rdata == $past(o_pipe_all[127:96]))
    else $error("last stage read data wrong");
  chk_tp_count: assert property (i_loadpipe && o_ctrl.transpose_ctrl[2] && !i_bus.wr
    |=> o_ctrl.transpose_ctrl == {1'b1, $past(o_ctrl.transpose_ctrl[1:0]) + 2'h1})
    else $error("transpose counter step wrong");
  chk_word_int: assert property (o_ctrl.operand_size == MCD_SINGLE_WORD
    && o_ctrl.operand_type == MCD_INTEGER && o_ctrl.out_shift == 3'b100 && $stable(o_ctrl)
    |-> o_word == $past(o_acc[31:0]))
    else $error("integer output word wrong");
endmodule

bind mcd_mac_control mcd_mac_control_props u_mcd_mac_control_props (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_basic_op(i_basic_op), .i_mac_step(i_mac_step), .i_product(i_product),
  .i_loadpipe(i_loadpipe), .i_inproduct(i_inproduct), .i_pipe_data(i_pipe_data),
  .o_ctrl(o_ctrl), .o_acc(o_acc), .o_word(o_word), .o_clip_enable(o_clip_enable),
  .o_pipe_last(o_pipe_last), .o_pipe_all(o_pipe_all)
);

// ### bench/mcd_exec_model.sv
// execution unit model: basic ops, accumulate steps and pipeline moves
`timescale 1ns/10ps

module mcd_exec_model
  import mcd_pkg::*;
(
  input wire logic i_clock,          // system clock
  output mcd_basic_op_t o_basic_op,  // basic multiply event
  output logic o_mac_step,           // accumulate step
  output logic [63:0] o_product,     // multiplier result
  output logic o_loadpipe,           // pipe-load pulse
  output logic o_inproduct,          // inner-product pulse
  output logic [31:0] o_pipe_data,   // pipeline column
  output logic [31:0] o_coef_row     // coefficient row
);
  initial begin
    o_basic_op = '0;
    o_mac_step = 1'b0;
    o_product = '0;
    o_loadpipe = 1'b0;
    o_inproduct = 1'b0;
    o_pipe_data = '0;
    o_coef_row = '0;
  end

  // ======================================================================
  // one-cycle requests; released data is inverted so stale values never pass
  task automatic basic(input logic [1:0] s, input logic [3:0] f);
    @(posedge i_clock);
    o_basic_op <= '{valid: 1'b1, mb_size: mcd_size_t'(s), func: f};
    @(posedge i_clock);
    o_basic_op <= '{valid: 1'b0, mb_size: mcd_size_t'(~s), func: ~f};
    #1;
  endtask

  task automatic step(input logic [63:0] p);
    @(posedge i_clock);
    o_mac_step <= 1'b1;
    o_product <= p;
    @(posedge i_clock);
    o_mac_step <= 1'b0;
    o_product <= ~p;
    #1;
  endtask

  task automatic pipe(input logic lp, input logic ip, input logic [31:0] d, input logic [31:0] r);
    @(posedge i_clock);
    o_loadpipe <= lp;
    o_inproduct <= ip;
    o_pipe_data <= d;
    o_coef_row <= r;
    @(posedge i_clock);
    o_loadpipe <= 1'b0;
    o_inproduct <= 1'b0;
    o_pipe_data <= ~d;
    o_coef_row <= ~r;
    #1;
  endtask
endmodule

// ### bench/tb_mcd_mac_control.sv
// self-checking bench for the mac control datapath
`timescale 1ns/10ps
`include "mcd_regs.svh"
`define CHK(a, e) begin n_tests++; \
  if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_mcd_mac_control
  import mcd_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  mcd_bus_req_t bus = '0;
  logic [31:0] rdata;
  mcd_basic_op_t basic_op;
  logic mac_step, loadpipe, inproduct, clip;
  logic [63:0] product, acc;
  logic [31:0] pipe_data, coef_row, word, pipe_last;
  mcd_ctrl_t ctrl;
  logic [127:0] pipe_all;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [2:0] ptt_w [4] = '{3'h0, 3'h5, 3'h2, 3'h4};
  logic [2:0] ptt_e [4] = '{3'h0, 3'h5, 3'h0, 3'h4};
  logic [31:0] mc_ctrl [8] = '{32'h6000_1000, 32'h6000_1000, 32'h0C00_2000, 32'h0800_3000,
                               32'h0000_5000, 32'h0000_4000, 32'h0800_6000, 32'h0000_0000};
  logic [63:0] mc_prod [8] = '{64'h11, 64'h22, 64'h0, 64'h5, 64'h0000_0100_0000_0000, 64'h7, 64'h9, 64'h3};
  logic [63:0] mc_acc [8] = '{64'h11, 64'h22, 64'h0, 64'h16, 64'h0000_0100_0000_0016,
                              64'h0000_0100_0000_0016, 64'h0000_0100_0000_0027, 64'h0};
  logic [31:0] ow_ctrl [8] = '{32'h0020_4400, 32'h0020_4500, 32'h0028_4400, 32'h0024_4400,
                               32'h0024_4700, 32'h0008_4400, 32'h0014_4400, 32'h002C_4400};
  logic [31:0] ow_exp [8] = '{32'h89AB_CDEF, 32'h1357_9BDE, 32'h4567_89AB, 32'h0123_4567,
                              32'h091A_2B3C, 32'h1256_9ADE, 32'h0123_89AB, 32'h89AB_CDEF};

  always #4 clock = ~clock;

  mcd_mac_control u_mcd_mac_control (
    .i_clock(clock), .i_arst_n(arst_n), .i_bus(bus), .o_rdata(rdata), .i_basic_op(basic_op),
    .i_mac_step(mac_step), .i_product(product), .i_loadpipe(loadpipe), .i_inproduct(inproduct),
    .i_pipe_data(pipe_data), .i_coef_row(coef_row), .o_ctrl(ctrl), .o_acc(acc), .o_word(word),
    .o_clip_enable(clip), .o_pipe_last(pipe_last), .o_pipe_all(pipe_all)
  );

  mcd_exec_model u_mcd_exec_model (
    .i_clock(clock), .o_basic_op(basic_op), .o_mac_step(mac_step), .o_product(product),
    .o_loadpipe(loadpipe), .o_inproduct(inproduct), .o_pipe_data(pipe_data), .o_coef_row(coef_row)
  );

  // ======================================================================
  // register bus tasks and closing report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ======================================================================
  // scenarios
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rchk(`MCD_CTRL_ONE_ADDR, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wr(`MCD_CTRL_ONE_ADDR, 32'hFFFF_FFFF);
    rchk(`MCD_CTRL_ONE_ADDR, 32'h6C3F_7F9F);
    `CHK(clip, 1'b1)
    foreach (ptt_w[k]) begin
      wr(`MCD_CTRL_ONE_ADDR, {29'h0, ptt_w[k]});
      `CHK(ctrl.transpose_ctrl, ptt_e[k])
    end
    for (int s = 0; s < 3; s++) begin
      for (int f = 0; f < 16; f++) begin
        u_mcd_exec_model.basic(2'(s), 4'(f));
        `CHK(ctrl[21:16], {2'(s), 4'(f)})
      end
    end
    wr(`MCD_RAM_PTRS_ADDR, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      wr(`MCD_CTRL_ONE_ADDR, mc_ctrl[k]);
      u_mcd_exec_model.step(mc_prod[k]);
      `CHK(acc, mc_acc[k])
      if (k == 6) begin
        rchk(`MCD_ACC_HI_ADDR, 32'h0000_0100);
      end
    end
    rchk(`MCD_RAM_PTRS_ADDR, 32'h0000_0201);
    wr(`MCD_CTRL_ONE_ADDR, 32'h0020_1000);
    u_mcd_exec_model.step(64'h0123_4567_89AB_CDEF);
    for (int k = 0; k < 8; k++) begin
      wr(`MCD_CTRL_ONE_ADDR, ow_ctrl[k]);
      repeat (2) @(posedge clock);
      #1;
      `CHK(word, ow_exp[k])
    end
    rchk(`MCD_WORD_OUT_ADDR, 32'h89AB_CDEF);
    wr(`MCD_CTRL_ONE_ADDR, 32'h0024_1C00);
    u_mcd_exec_model.step(64'h0000_0000_8000_0000);
    `CHK(acc, 64'h0000_0001_0000_0000)
    @(posedge clock);
    #1;
    `CHK(word, 32'h0000_0001)
    wr(`MCD_CTRL_ONE_ADDR, 32'h0000_0010);
    for (int k = 1; k < 5; k++) begin
      u_mcd_exec_model.pipe(1'b1, 1'b0, 32'hD0D0_D0D0, 32'h0101_0101 * k);
    end
    `CHK(pipe_all, 128'h0)
    wr(`MCD_CTRL_ONE_ADDR, 32'h0000_000C);
    for (int k = 0; k < 4; k++) begin
      u_mcd_exec_model.pipe(1'b1, 1'b0, 32'hD000_0000 + k, 32'hFFFF_FFFF);
      `CHK(ctrl.transpose_ctrl, {1'b1, 2'(k + 1)})
      if (k == 0) begin
        `CHK(pipe_all, 128'h0404_0404_0303_0303_0202_0202_0101_0101)
      end
    end
    `CHK(pipe_all, 128'h0101_0101_D000_0001_D000_0002_D000_0003)
    u_mcd_exec_model.pipe(1'b0, 1'b1, 32'hE000_0000, 32'hFFFF_FFFF);
    `CHK(pipe_all, 128'hD000_0001_D000_0002_D000_0003_E000_0000)
    `CHK(pipe_last, 32'hD000_0001)
    rchk(`MCD_PIPE_OUT_ADDR, 32'hD000_0001);
    u_mcd_exec_model.pipe(1'b1, 1'b0, 32'hD000_0009, 32'hFFFF_FFFF);
    `CHK(pipe_all, 128'h0404_0404_0303_0303_0202_0202_0101_0101)
    wr(`MCD_CTRL_ONE_ADDR, 32'h0000_0008);
    u_mcd_exec_model.pipe(1'b1, 1'b0, 32'hD000_000A, 32'hFFFF_FFFF);
    `CHK(pipe_all, 128'h0303_0303_0202_0202_0101_0101_D000_000A)
    end_of_test();
  end
endmodule
